// File: src/pwt_delay.sv
`timescale 1ns/1ps
module pwt_delay (
	input wire logic i_mclk,
	input wire logic i_rst,
	input wire logic [1:0] i_prescaler,
	input wire logic [1:0] i_trigger_select,
	input wire logic [1:0] i_function_select,
	input wire logic [7:0] i_length,
	input wire logic i_cmp_a_set,
	input wire logic i_cmp_a_clr,
	input wire logic i_cmp_b_set,
	input wire logic i_cmp_b_clr,
	output logic o_blanking,
	output logic o_event_out
);
	import pwt_pkg::*;

	pwt_dly_state_e state; // delay running or not
	pwt_dly_state_e next_state;
	logic [2:0] presc_cnt; // prescaler phase
	logic [7:0] remain; // prescaled ticks still to go

	// selectable start events, indexed by the trigger code
	wire [3:0] trig_vec = {i_cmp_b_clr, i_cmp_b_set, i_cmp_a_clr, i_cmp_a_set};
	wire used = (i_function_select == DLY_BLANK) || (i_function_select == DLY_EVENT);
	wire trig_hit = used && trig_vec[i_trigger_select];
	// divide by 1, 2, 4 or 8
	wire [2:0] presc_top = 3'h7 >> (2'h3 - i_prescaler);
	wire tick = (presc_cnt == presc_top);
	wire finish = (state == DLY_RUN) && (remain == 8'h00) && tick && !trig_hit;

	// a fresh trigger restarts a running delay
	always_comb begin
		case (state)
			DLY_IDLE: next_state = trig_hit ? DLY_RUN : DLY_IDLE;
			DLY_RUN: next_state = (finish || !used) ? DLY_IDLE : DLY_RUN;
			default: next_state = DLY_IDLE;
		endcase
	end

	// counters and state
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			state <= DLY_IDLE;
			presc_cnt <= 3'h0;
			remain <= 8'h00;
		end else begin
			state <= next_state;
			presc_cnt <= (trig_hit || tick) ? 3'h0 : presc_cnt + 3'h1;
			if (trig_hit) begin
				remain <= i_length;
			end else if (tick && remain != 8'h00) begin
				remain <= remain - 8'h01;
			end
		end
	end

	// event output is a one-cycle pulse at the end of the delay
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			o_event_out <= 1'b0;
		end else begin
			o_event_out <= finish && (i_function_select == DLY_EVENT);
		end
	end

	assign o_blanking = (state == DLY_RUN) && (i_function_select == DLY_BLANK);
endmodule : pwt_delay

// File: src/pwt_mode_decode.sv
`timescale 1ns/1ps
module pwt_mode_decode (
	input wire logic [3:0] i_mode,
	output logic o_active,
	output logic o_stop_all,
	output logic o_level_hold,
	output logic o_wait_software,
	output logic o_jump_opposite,
	output logic o_run_opposite,
	output logic o_jump_next,
	output logic o_keep_frequency,
	output logic o_dead_time
);
	import pwt_pkg::*;

	// unassigned codes above the last mode fall out as no action
	assign o_active = (i_mode != MODE_NONE) && (i_mode <= MODE_LEVEL_STOP_KEEP_FREQUENCY);
	// codes four to seven stop every output
	assign o_stop_all = (i_mode >= MODE_KEEP_FREQUENCY) && (i_mode <= MODE_WAIT_FOR_SOFTWARE);
	// these reactions last only while the fault level stands
	assign o_level_hold = (i_mode == MODE_RUN_OPPOSITE_DURING_FAULT) ||
		(i_mode == MODE_DEAD_TIME_DURING_FAULT) ||
		(i_mode == MODE_LEVEL_STOP_KEEP_FREQUENCY);
	assign o_wait_software = (i_mode == MODE_WAIT_FOR_SOFTWARE);
	assign o_jump_opposite = (i_mode == MODE_JUMP_OPPOSITE_WAIT);
	assign o_run_opposite = (i_mode == MODE_RUN_OPPOSITE_WAIT) ||
		(i_mode == MODE_RUN_OPPOSITE_DURING_FAULT);
	assign o_jump_next = (i_mode == MODE_JUMP_NEXT_WAIT) ||
		(i_mode == MODE_EDGE_STOP_NEXT_CYCLE);
	assign o_keep_frequency = (i_mode == MODE_KEEP_FREQUENCY) ||
		(i_mode == MODE_EDGE_STOP_KEEP_FREQUENCY) ||
		(i_mode == MODE_LEVEL_STOP_KEEP_FREQUENCY);
	assign o_dead_time = (i_mode == MODE_DEAD_TIME_DURING_FAULT);
endmodule : pwt_mode_decode

// File: src/pwt_pkg.sv
package pwt_pkg;
	// register byte offsets
	localparam logic [7:0] ADDR_INT_FLAGS = 8'h0D;
	localparam logic [7:0] ADDR_STATUS = 8'h0E;
	localparam logic [7:0] ADDR_INPUT_A = 8'h10;
	localparam logic [7:0] ADDR_INPUT_B = 8'h11;
	localparam logic [7:0] ADDR_FAULT_CTRL = 8'h12;
	localparam logic [7:0] ADDR_DELAY_CTRL = 8'h14;
	localparam logic [7:0] ADDR_DELAY_VALUE = 8'h15;
	// interrupt flag positions
	localparam int unsigned FLAG_CYCLE_END = 0;
	localparam int unsigned FLAG_TRIG_A = 2;
	localparam int unsigned FLAG_TRIG_B = 3;
	// status positions
	localparam int unsigned STAT_EN_RDY = 0;
	localparam int unsigned STAT_CMD_RDY = 1;
	localparam int unsigned STAT_ACT_A = 6;
	localparam int unsigned STAT_ACT_B = 7;
	// fault control fields
	localparam int unsigned FAULT_LVL_LSB = 0;
	localparam int unsigned FAULT_EN_LSB = 4;
	// delay control fields
	localparam int unsigned DLY_SEL_LSB = 0;
	localparam int unsigned DLY_TRIG_LSB = 2;
	localparam int unsigned DLY_PRESC_LSB = 4;
	// writable masks
	localparam logic [7:0] FLAGS_MASK = 8'h0D;
	localparam logic [7:0] MODE_MASK = 8'h0F;
	localparam logic [7:0] DELAY_CTRL_MASK = 8'h3F;
	// reset values
	localparam logic [7:0] RST_INT_FLAGS = 8'h00;
	localparam logic [7:0] RST_FAULT_CTRL = 8'h00;
	localparam logic [7:0] RST_DELAY_CTRL = 8'h00;
	localparam logic [7:0] RST_DELAY_VALUE = 8'h00;
	localparam logic [3:0] RST_MODE = 4'h0;
	// cycles for a command or enable to cross into the timer side
	localparam int unsigned CROSS_CYCLES = 3;

	// reaction of an input to its fault event
	typedef enum logic [3:0] {
		MODE_NONE = 4'h0,
		MODE_JUMP_OPPOSITE_WAIT = 4'h1,
		MODE_RUN_OPPOSITE_WAIT = 4'h2,
		MODE_RUN_OPPOSITE_DURING_FAULT = 4'h3,
		MODE_KEEP_FREQUENCY = 4'h4,
		MODE_DEAD_TIME_DURING_FAULT = 4'h5,
		MODE_JUMP_NEXT_WAIT = 4'h6,
		MODE_WAIT_FOR_SOFTWARE = 4'h7,
		MODE_EDGE_STOP_NEXT_CYCLE = 4'h8,
		MODE_EDGE_STOP_KEEP_FREQUENCY = 4'h9,
		MODE_LEVEL_STOP_KEEP_FREQUENCY = 4'hA
	} pwt_mode_e;

	// delay function
	typedef enum logic [1:0] {
		DLY_OFF = 2'h0,
		DLY_BLANK = 2'h1,
		DLY_EVENT = 2'h2,
		DLY_RESERVED = 2'h3
	} pwt_dly_sel_e;

	// delay counter state
	typedef enum logic [0:0] {
		DLY_IDLE = 1'h0,
		DLY_RUN = 1'h1
	} pwt_dly_state_e;
endpackage : pwt_pkg

// File: src/pwt_status_fault_delay.sv
// Local design decision: the address-and-strobe port.
`timescale 1ns/1ps
// Operation
// - input B event or capture sets flag three
// - input A event or capture sets flag two
// - every cycle end sets flag zero
// - writing one clears a flag, zero keeps
// - any level change of output B sets bit seven
// - any level change of output A sets bit six
// - activity stays set until software writes one
// - command ready rises once the command crossed
// - command strobes drop command ready
// - auto update plus compare B high write drops it
// - enable ready rises once enable crossed
// - enable write, disable strobe, debug break without run in debug drop it
// - modes one to three act on own output
// - modes four to seven stop all outputs
// - modes eight to ten stop on edge or level
// - enable bits drive channel pins A to D
// - level bits give reset and fault levels
// - fault control zero on power-on, else fuse
// - prescaler divides delay clock by 1,2,4,8
// - trigger field picks compare start event
// - select picks blanking or event delay
// - delay length counts prescaled timer cycles
module pwt_status_fault_delay #(
	parameter int unsigned SYNC_CYCLES = pwt_pkg::CROSS_CYCLES
) (
	input wire logic i_mclk,
	input wire logic i_rst_n, // every reset, synchronous
	input wire logic i_por_n, // power-on reset, synchronous
	input wire logic [7:0] i_timer_config_fuse,
	input wire logic [7:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [7:0] o_rdata,
	input wire logic i_sync_at_cycle_end_strobe,
	input wire logic i_sync_now_strobe,
	input wire logic i_restart_strobe,
	input wire logic i_soft_capture_a_strobe,
	input wire logic i_soft_capture_b_strobe,
	input wire logic i_auto_update,
	input wire logic i_compare_b_clear_high_write,
	input wire logic i_enable_write,
	input wire logic i_disable_at_cycle_end_strobe,
	input wire logic i_run_in_debug,
	input wire logic i_debug_break,
	input wire logic i_cycle_end,
	input wire logic i_capture_a_event,
	input wire logic i_capture_b_event,
	input wire logic i_compare_a_set_point,
	input wire logic i_compare_a_clear_point,
	input wire logic i_compare_b_set_point,
	input wire logic i_compare_b_clear_point,
	input wire logic i_waveform_out_a,
	input wire logic i_waveform_out_b,
	input wire logic [3:0] i_compare_out,
	input wire logic [1:0] i_fault_pin, // bit 0 input A, bit 1 input B
	output logic [3:0] o_pin_level,
	output logic [3:0] o_pin_oe,
	output logic o_delay_event,
	output logic o_stop_all,
	output logic [1:0] o_jump_opposite,
	output logic [1:0] o_run_opposite,
	output logic [1:0] o_jump_next,
	output logic [1:0] o_keep_frequency,
	output logic [1:0] o_dead_time,
	output logic [1:0] o_wait_software
);
	import pwt_pkg::*;

	// counter below holds up to fifteen
	if (SYNC_CYCLES < 1 || SYNC_CYCLES > 15) begin : g_bad_sync
		$error("SYNC_CYCLES must lie in 1 to 15");
	end

	localparam logic [3:0] SYNC_LOAD = 4'(SYNC_CYCLES);

	// address hit, shared by the write and read decoders
	function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] target);
		return addr == target;
	endfunction : reg_hit

	logic [7:0] int_flags; // sticky event flags
	logic [7:0] next_flags;
	logic act_a; // activity on waveform A
	logic act_b; // activity on waveform B
	logic wave_prev_a; // last level of waveform A
	logic wave_prev_b; // last level of waveform B
	logic [3:0] mode_a; // reaction mode of input A
	logic [3:0] mode_b; // reaction mode of input B
	logic [7:0] fault_ctrl; // pin enables and fault levels
	logic [7:0] delay_ctrl; // prescaler, trigger, function
	logic [7:0] delay_value; // delay length
	logic [3:0] cmd_wait; // cycles until command has crossed
	logic [3:0] en_wait; // cycles until enable has crossed
	logic reset_hold; // outputs at fault levels until first cycle end
	logic blanking; // fault inputs masked
	logic [1:0] trig_set; // per-input flag set
	logic [1:0] fault_now; // per-input reaction in force
	logic [1:0] stop_all_now; // all-output stop in force
	logic [1:0] single_now; // own-output stop in force
	logic [1:0] jo_now;
	logic [1:0] ro_now;
	logic [1:0] jn_now;
	logic [1:0] kf_now;
	logic [1:0] dt_now;
	logic [1:0] ws_now;

	// every reset clears the plain state; power-on is a reset too
	wire rst_any = !i_rst_n || !i_por_n;

	// write decode
	wire wr_flags = i_wr && reg_hit(i_addr, ADDR_INT_FLAGS);
	wire wr_status = i_wr && reg_hit(i_addr, ADDR_STATUS);
	wire wr_mode_a = i_wr && reg_hit(i_addr, ADDR_INPUT_A);
	wire wr_mode_b = i_wr && reg_hit(i_addr, ADDR_INPUT_B);
	wire wr_fault = i_wr && reg_hit(i_addr, ADDR_FAULT_CTRL);
	wire wr_dly_ctrl = i_wr && reg_hit(i_addr, ADDR_DELAY_CTRL);
	wire wr_dly_value = i_wr && reg_hit(i_addr, ADDR_DELAY_VALUE);

	// ready tracking sources
	wire cmd_clear = i_sync_at_cycle_end_strobe || i_sync_now_strobe || i_restart_strobe ||
		i_soft_capture_a_strobe || i_soft_capture_b_strobe;
	wire cmd_clear_all = cmd_clear || (i_auto_update && i_compare_b_clear_high_write);
	wire en_clear = i_enable_write || i_disable_at_cycle_end_strobe ||
		(i_debug_break && !i_run_in_debug);
	wire cmd_ready = (cmd_wait == 4'h0);
	wire en_ready = (en_wait == 4'h0);

	// activity edge detect on the waveform outputs
	wire chg_a = i_waveform_out_a != wave_prev_a;
	wire chg_b = i_waveform_out_b != wave_prev_b;
	wire clr_act_a = wr_status && i_wdata[STAT_ACT_A];
	wire clr_act_b = wr_status && i_wdata[STAT_ACT_B];

	// flag update: a set in the clearing cycle wins
	always_comb begin
		next_flags = int_flags & ~(wr_flags ? (i_wdata & FLAGS_MASK) : 8'h00);
		next_flags[FLAG_CYCLE_END] = next_flags[FLAG_CYCLE_END] || i_cycle_end;
		next_flags[FLAG_TRIG_A] = next_flags[FLAG_TRIG_A] || trig_set[0];
		next_flags[FLAG_TRIG_B] = next_flags[FLAG_TRIG_B] || trig_set[1];
	end

	// flags and activity bits
	always_ff @(posedge i_mclk) begin
		if (rst_any) begin
			int_flags <= RST_INT_FLAGS;
			act_a <= 1'b0;
			act_b <= 1'b0;
		end else begin
			int_flags <= next_flags;
			act_a <= (act_a && !clr_act_a) || chg_a;
			act_b <= (act_b && !clr_act_b) || chg_b;
		end
	end

	// waveform history; taking the live level at reset avoids a false toggle
	always_ff @(posedge i_mclk) begin
		wave_prev_a <= i_waveform_out_a;
		wave_prev_b <= i_waveform_out_b;
	end

	// crossing counters; reset starts a crossing so both bits read low first
	always_ff @(posedge i_mclk) begin
		if (rst_any || cmd_clear_all) begin
			cmd_wait <= SYNC_LOAD;
		end else if (cmd_wait != 4'h0) begin
			cmd_wait <= cmd_wait - 4'h1;
		end
		if (rst_any || en_clear) begin
			en_wait <= SYNC_LOAD;
		end else if (en_wait != 4'h0) begin
			en_wait <= en_wait - 4'h1;
		end
	end

	// configuration registers
	always_ff @(posedge i_mclk) begin
		if (rst_any) begin
			mode_a <= RST_MODE;
			mode_b <= RST_MODE;
			delay_ctrl <= RST_DELAY_CTRL;
			delay_value <= RST_DELAY_VALUE;
		end else begin
			if (wr_mode_a) begin
				mode_a <= i_wdata[3:0];
			end
			if (wr_mode_b) begin
				mode_b <= i_wdata[3:0];
			end
			if (wr_dly_ctrl) begin
				delay_ctrl <= i_wdata & DELAY_CTRL_MASK;
			end
			if (wr_dly_value) begin
				delay_value <= i_wdata;
			end
		end
	end

	// fault control survives warm resets by reloading the fuse image
	always_ff @(posedge i_mclk) begin
		if (!i_por_n) begin
			fault_ctrl <= RST_FAULT_CTRL;
		end else if (!i_rst_n) begin
			fault_ctrl <= i_timer_config_fuse;
		end else if (wr_fault) begin
			fault_ctrl <= i_wdata;
		end
	end

	// blanking and event delay
	pwt_delay u_delay (
		.i_mclk(i_mclk),
		.i_rst(rst_any),
		.i_prescaler(delay_ctrl[DLY_PRESC_LSB +: 2]),
		.i_trigger_select(delay_ctrl[DLY_TRIG_LSB +: 2]),
		.i_function_select(delay_ctrl[DLY_SEL_LSB +: 2]),
		.i_length(delay_value),
		.i_cmp_a_set(i_compare_a_set_point),
		.i_cmp_a_clr(i_compare_a_clear_point),
		.i_cmp_b_set(i_compare_b_set_point),
		.i_cmp_b_clr(i_compare_b_clear_point),
		.o_blanking(blanking),
		.o_event_out(o_delay_event)
	);

	// per-input fault path
	for (genvar gi = 0; gi < 2; gi++) begin : g_input
		logic [2:0] sync_ff; // pin synchroniser
		logic level; // filtered fault level
		logic prev_level;
		logic latched; // reaction held after an edge
		logic d_active;
		logic d_stop_all;
		logic d_level_hold;
		logic d_wait_sw;
		logic d_jo;
		logic d_ro;
		logic d_jn;
		logic d_kf;
		logic d_dt;
		wire [3:0] mode_sel = (gi == 0) ? mode_a : mode_b;
		wire capture = (gi == 0) ? i_capture_a_event : i_capture_b_event;
		wire rise = level && !prev_level && !blanking;
		// wait-for-software holds until restart, the rest until a quiet cycle end
		wire release_now = d_wait_sw ? i_restart_strobe : (i_cycle_end && !level);

		pwt_mode_decode u_decode (
			.i_mode(mode_sel),
			.o_active(d_active),
			.o_stop_all(d_stop_all),
			.o_level_hold(d_level_hold),
			.o_wait_software(d_wait_sw),
			.o_jump_opposite(d_jo),
			.o_run_opposite(d_ro),
			.o_jump_next(d_jn),
			.o_keep_frequency(d_kf),
			.o_dead_time(d_dt)
		);

		// level changes once the second and third stage agree
		always_ff @(posedge i_mclk) begin
			sync_ff <= {sync_ff[1:0], i_fault_pin[gi]};
			if (rst_any) begin
				level <= 1'b0;
				prev_level <= 1'b0;
				latched <= 1'b0;
			end else begin
				if (sync_ff[1] == sync_ff[2]) begin
					level <= sync_ff[2];
				end
				prev_level <= level;
				// a new edge outranks the release
				if (rise && d_active && !d_level_hold) begin
					latched <= 1'b1;
				end else if (release_now || !d_active) begin
					latched <= 1'b0;
				end
			end
		end

		assign trig_set[gi] = rise || capture;
		assign fault_now[gi] = d_active &&
			(d_level_hold ? (level && !blanking) : latched);
		assign stop_all_now[gi] = fault_now[gi] && d_stop_all;
		assign single_now[gi] = fault_now[gi] && !d_stop_all;
		assign jo_now[gi] = fault_now[gi] && d_jo;
		assign ro_now[gi] = fault_now[gi] && d_ro;
		assign jn_now[gi] = fault_now[gi] && d_jn;
		assign kf_now[gi] = fault_now[gi] && d_kf;
		assign dt_now[gi] = fault_now[gi] && d_dt;
		assign ws_now[gi] = fault_now[gi] && d_wait_sw;
	end

	// which channels show their fault level; input A owns channel A, B owns B
	wire [3:0] override = {4{reset_hold || (|stop_all_now)}} | {2'b00, single_now};
	wire [3:0] next_pin = (override & fault_ctrl[FAULT_LVL_LSB +: 4]) |
		(~override & i_compare_out);

	// pin levels and reactions toward the counter
	always_ff @(posedge i_mclk) begin
		if (rst_any) begin
			reset_hold <= 1'b1;
			o_pin_level <= 4'h0;
			o_stop_all <= 1'b0;
			o_jump_opposite <= 2'h0;
			o_run_opposite <= 2'h0;
			o_jump_next <= 2'h0;
			o_keep_frequency <= 2'h0;
			o_dead_time <= 2'h0;
			o_wait_software <= 2'h0;
		end else begin
			if (i_cycle_end) begin
				reset_hold <= 1'b0;
			end
			o_pin_level <= next_pin;
			o_stop_all <= |stop_all_now;
			o_jump_opposite <= jo_now;
			o_run_opposite <= ro_now;
			o_jump_next <= jn_now;
			o_keep_frequency <= kf_now;
			o_dead_time <= dt_now;
			o_wait_software <= ws_now;
		end
	end

	// pin enables straight from the register
	assign o_pin_oe = fault_ctrl[FAULT_EN_LSB +: 4];

	// read selection; unmapped offsets read zero
	wire [7:0] status_value = {act_b, act_a, 4'h0, cmd_ready, en_ready};
	wire [7:0] rd_value =
		reg_hit(i_addr, ADDR_INT_FLAGS) ? int_flags :
		reg_hit(i_addr, ADDR_STATUS) ? status_value :
		reg_hit(i_addr, ADDR_INPUT_A) ? {4'h0, mode_a} :
		reg_hit(i_addr, ADDR_INPUT_B) ? {4'h0, mode_b} :
		reg_hit(i_addr, ADDR_FAULT_CTRL) ? fault_ctrl :
		reg_hit(i_addr, ADDR_DELAY_CTRL) ? delay_ctrl :
		reg_hit(i_addr, ADDR_DELAY_VALUE) ? delay_value : 8'h00;

	// read data stands only in the cycle after the strobe
	always_ff @(posedge i_mclk) begin
		if (rst_any) begin
			o_rdata <= 8'h00;
		end else begin
			o_rdata <= i_rd ? rd_value : 8'h00;
		end
	end

	// command crossing with no further strobe for three cycles
	sequence cmd_quiet_s;
		cmd_clear_all ##1 !cmd_clear_all [*3];
	endsequence
	// enable crossing with no further clear for three cycles
	sequence en_quiet_s;
		en_clear ##1 !en_clear [*3];
	endsequence

	ovf_flag_set_a: assert property (@(posedge i_mclk) disable iff (rst_any)
		i_cycle_end |=> int_flags[FLAG_CYCLE_END]) else $error("cycle end flag not set");
	trig_a_set_a: assert property (@(posedge i_mclk) disable iff (rst_any)
		trig_set[0] |=> int_flags[FLAG_TRIG_A]) else $error("trigger A flag not set");
	trig_b_set_a: assert property (@(posedge i_mclk) disable iff (rst_any)
		trig_set[1] |=> int_flags[FLAG_TRIG_B]) else $error("trigger B flag not set");
	flag_w1c_a: assert property (@(posedge i_mclk) disable iff (rst_any)
		wr_flags && i_wdata[FLAG_CYCLE_END] && !i_cycle_end |=> !int_flags[FLAG_CYCLE_END])
		else $error("cycle end flag not cleared");
	flag_keep_a: assert property (@(posedge i_mclk) disable iff (rst_any)
		int_flags[FLAG_TRIG_A] && !(wr_flags && i_wdata[FLAG_TRIG_A]) |=> int_flags[FLAG_TRIG_A])
		else $error("trigger A flag lost");
	act_a_set_a: assert property (@(posedge i_mclk) disable iff (rst_any)
		i_waveform_out_a != $past(i_waveform_out_a) |=> act_a) else $error("activity A missed");
	act_b_hold_a: assert property (@(posedge i_mclk) disable iff (rst_any)
		act_b && !clr_act_b |=> act_b) else $error("activity B dropped");
	cmd_drop_a: assert property (@(posedge i_mclk) disable iff (rst_any)
		cmd_clear_all |=> !cmd_ready [*3]) else $error("command ready not held low");
	cmd_rise_a: assert property (@(posedge i_mclk) disable iff (rst_any)
		cmd_quiet_s |=> cmd_ready) else $error("command ready late");
	en_rise_a: assert property (@(posedge i_mclk) disable iff (rst_any)
		en_quiet_s |=> en_ready) else $error("enable ready late");
	en_drop_a: assert property (@(posedge i_mclk) disable iff (rst_any)
		i_debug_break && !i_run_in_debug |=> !en_ready) else $error("enable ready not dropped");
	pin_oe_a: assert property (@(posedge i_mclk) disable iff (rst_any)
		wr_fault |=> o_pin_oe == $past(i_wdata[7:4])) else $error("pin enable mismatch");
	reset_level_a: assert property (@(posedge i_mclk) disable iff (rst_any)
		reset_hold && !i_cycle_end |=> o_pin_level == $past(fault_ctrl[3:0]))
		else $error("reset level not shown");
endmodule : pwt_status_fault_delay

// File: tb/pwt_pin_model.sv
`timescale 1ns/1ps
// far-side output stage: flips a waveform pin on request
module pwt_pin_model (
	input wire logic i_mclk,
	input wire logic [1:0] i_flip,
	output logic o_waveform_out_a,
	output logic o_waveform_out_b,
	output logic [3:0] o_compare_out
);
	// pins start low so no activity is seen before the first request
	initial begin
		o_waveform_out_a = 1'b0;
		o_waveform_out_b = 1'b0;
	end
	// a flip lands one edge after the request, like a real output latch
	always @(posedge i_mclk) begin
		if (i_flip[0]) o_waveform_out_a <= ~o_waveform_out_a;
		if (i_flip[1]) o_waveform_out_b <= ~o_waveform_out_b;
	end
	// channels c and d stay low; a and b follow the waveforms
	assign o_compare_out = {2'b00, o_waveform_out_b, o_waveform_out_a};
endmodule : pwt_pin_model

// File: tb/pwt_status_fault_delay_tb.sv
`timescale 1ns/1ps
module pwt_status_fault_delay_tb;
	logic mclk = 1'b0, rst_n = 1'b0, por_n = 1'b0, wr = 1'b0, rd = 1'b0;
	logic auto_update = 1'b1, run_dbg = 1'b1, dbg_brk = 1'b0;
	logic [7:0] fuse = 8'h00, addr = 8'h00, wdata = 8'h00, rdata;
	logic [16:0] ev = '0; // one-cycle event strobes, see instance map
	logic [1:0] fault = 2'b00;
	logic [3:0] pin_level, cmp_out, pin_oe;
	logic [1:0] jo, ro, jn, kf, dt, ws; // reaction outputs, bit 0 input A
	logic [7:0] f_list [7] = '{8'h0D, 8'h10, 8'h11, 8'h12, 8'h14, 8'h15, 8'h13};
	logic delay_event, stop_all, wa, wb;
	int err_count = 0, checks = 0;
	always #5 mclk = ~mclk;
	pwt_pin_model u_pwt_pin_model (.i_mclk(mclk), .i_flip(ev[16:15]), .o_waveform_out_a(wa),
		.o_waveform_out_b(wb), .o_compare_out(cmp_out));
	pwt_status_fault_delay u_pwt_status_fault_delay (.i_mclk(mclk), .i_rst_n(rst_n),
		.i_por_n(por_n), .i_timer_config_fuse(fuse), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
		.i_rd(rd), .o_rdata(rdata), .i_sync_at_cycle_end_strobe(ev[0]), .i_sync_now_strobe(ev[1]),
		.i_restart_strobe(ev[2]), .i_soft_capture_a_strobe(ev[3]), .i_soft_capture_b_strobe(ev[4]),
		.i_auto_update(auto_update), .i_compare_b_clear_high_write(ev[5]), .i_enable_write(ev[6]),
		.i_disable_at_cycle_end_strobe(ev[7]), .i_run_in_debug(run_dbg), .i_debug_break(dbg_brk),
		.i_cycle_end(ev[8]), .i_capture_a_event(ev[9]), .i_capture_b_event(ev[10]),
		.i_compare_a_set_point(ev[11]), .i_compare_a_clear_point(ev[12]),
		.i_compare_b_set_point(ev[13]), .i_compare_b_clear_point(ev[14]), .i_waveform_out_a(wa),
		.i_waveform_out_b(wb), .i_compare_out(cmp_out), .i_fault_pin(fault),
		.o_pin_level(pin_level), .o_pin_oe(pin_oe), .o_delay_event(delay_event),
		.o_stop_all(stop_all), .o_jump_opposite(jo), .o_run_opposite(ro), .o_jump_next(jn),
		.o_keep_frequency(kf), .o_dead_time(dt), .o_wait_software(ws));
	// compare and count
	task chk(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp) begin
			err_count++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge mclk);
		wr <= 1'b0;
	endtask : wr_reg
	// read data stands only in the cycle after the strobe
	task rd_chk(input logic [7:0] a, input logic [7:0] exp);
		@(posedge mclk);
		addr <= a;
		rd <= 1'b1;
		@(posedge mclk);
		rd <= 1'b0;
		#1;
		chk(rdata, exp);
	endtask : rd_chk
	task pulse(input int b);
		@(posedge mclk);
		ev[b] <= 1'b1;
		@(posedge mclk);
		ev[b] <= 1'b0;
	endtask : pulse
	task report_and_stop;
		if (err_count == 0 && checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : report_and_stop
	// hang guard, far above the expected run length
	initial begin
		repeat (20000) @(posedge mclk);
		err_count++;
		report_and_stop();
	end
	initial begin
		int n;
		logic [7:0] f;
		repeat (6) @(posedge mclk);
		rst_n <= 1'b1;
		por_n <= 1'b1;
		// reset values, 0x13 is unmapped
		foreach (f_list[i]) rd_chk(f_list[i], 8'h00);
		repeat (5) @(posedge mclk);
		for (int i = 0; i < 8; i++) begin
			pulse(i);
			rd_chk(8'h0E, (i < 6) ? 8'h01 : 8'h02);
			repeat (5) @(posedge mclk);
			rd_chk(8'h0E, 8'h03);
		end
		// compare-B high write alone must not drop command ready
		auto_update <= 1'b0;
		pulse(5);
		rd_chk(8'h0E, 8'h03);
		dbg_brk <= 1'b1;
		rd_chk(8'h0E, 8'h03);
		run_dbg <= 1'b0;
		repeat (2) @(posedge mclk);
		rd_chk(8'h0E, 8'h02);
		dbg_brk <= 1'b0;
		repeat (6) @(posedge mclk);
		// soft capture strobes above only drop command ready; clear all flags anyway
		wr_reg(8'h0D, 8'hFF);
		for (int i = 0; i < 3; i++) begin
			f = 8'(1 << (i + (i > 0)));
			pulse(8 + i);
			rd_chk(8'h0D, f);
			wr_reg(8'h0D, 8'h00);
			rd_chk(8'h0D, f);
			wr_reg(8'h0D, 8'hFF);
			rd_chk(8'h0D, 8'h00);
		end
		for (int i = 0; i < 2; i++) begin
			f = 8'h03 | (8'h40 << i);
			pulse(15 + i);
			rd_chk(8'h0E, f);
			wr_reg(8'h0E, 8'h40 << i);
			rd_chk(8'h0E, 8'h03);
			pulse(15 + i);
			rd_chk(8'h0E, f);
			wr_reg(8'h0E, 8'hFF);
		end
		wr_reg(8'h12, 8'hA5);
		rd_chk(8'h12, 8'hA5);
		chk({4'h0, pin_oe}, 8'h0A);
		fuse <= 8'h3C;
		rst_n <= 1'b0;
		repeat (4) @(posedge mclk);
		rst_n <= 1'b1;
		rd_chk(8'h12, 8'h3C);
		// all fault levels high, outputs disabled
		wr_reg(8'h12, 8'h0F);
		pulse(8);
		for (int m = 0; m < 16; m++) begin
			wr_reg(8'h10, 8'hF0 | 8'(m));
			rd_chk(8'h10, 8'(m));
			fault[0] <= 1'b1;
			repeat (10) @(posedge mclk);
			f = (m >= 4 && m <= 7) ? 8'h0F : ((m >= 1 && m <= 10) ? 8'h01 : 8'h00);
			chk({4'h0, pin_level}, f);
			chk({7'h0, stop_all}, 8'(m >= 4 && m <= 7));
			chk({2'h0, ws[0], dt[0], kf[0], jn[0], ro[0], jo[0]}, {2'h0, m == 7, m == 5,
				m == 4 || m == 9 || m == 10, m == 6 || m == 8, m == 2 || m == 3, m == 1});
			fault[0] <= 1'b0;
			repeat (10) @(posedge mclk);
			pulse(8);
			pulse(2);
			repeat (3) @(posedge mclk);
			chk({4'h0, pin_level}, 8'h00);
		end
		// input B owns channel B and its own trigger flag
		wr_reg(8'h11, 8'h01);
		fault[1] <= 1'b1;
		repeat (10) @(posedge mclk);
		chk({4'h0, pin_level}, 8'h02);
		chk({6'h0, jo}, 8'h02);
		rd_chk(8'h0D, 8'h0D);
		fault[1] <= 1'b0;
		wr_reg(8'h11, 8'h00);
		wr_reg(8'h14, 8'hFF);
		rd_chk(8'h14, 8'h3F);
		wr_reg(8'h15, 8'h03);
		// event delay of length 3, trigger code and prescaler stepped together
		for (int p = 0; p < 4; p++) begin
			wr_reg(8'h14, 8'(p * 20 + 2));
			pulse(11 + (p + 1) % 4);
			n = 0;
			repeat (40) begin
				@(posedge mclk);
				#1;
				if (delay_event === 1'b1) n++;
			end
			chk(8'(n), 8'h00);
			pulse(11 + p);
			n = 0;
			while (delay_event !== 1'b1 && n < 100) begin
				@(posedge mclk);
				#1;
				n++;
			end
			chk(8'(n >= (4 << p) - 1 && n <= (4 << p) + (1 << p) + 1), 8'h01);
		end
		report_and_stop();
	end
endmodule : pwt_status_fault_delay_tb
